//--- verilog/qdc_quadrature_decoder.v
// Quadrature decoder, up/down position counter, read latch and byte bus.
// Assumes one free-running clock, encoder phases and bus pins from outside.
`timescale 1ns/1ps
`include "qdc_regs.vh"

////////////////////////////////////////////////////////////////////////////////

// How it works
// - Clear input low zeroes counter, read latch and the read-inhibit logic.
// - Clear acts asynchronously, independent of clock and other inputs.
// - Byte bus driven only while output-enable is low, else released.
// - Output-enable and byte-choose sampled on falling edge steer latch loading.
// - Byte-choose picks which latch byte appears on the 8-bit byte bus.
// - Position read as two bytes: high byte (bits 8-15) first, then low byte.
// - With a 12-bit counter the top four bits of the high byte read zero.
// - Each valid filtered phase transition gives a step pulse while count enable is set.
// - Direction output high for up, low for down, settled before pulses rise.
// - Counter overflow or underflow gives a wrap pulse.
// - Step and wrap pulses rise after rising edge, fall after next falling edge.
// - Each phase is sampled every rising edge into a four-bit history.
// - Filtered phase changes only after three equal consecutive samples.
// - Pulses under two periods and spikes between edges are rejected.
// - Every edge of both filtered phases counts: four counts per cycle.
// - Previous and present phase states give a count strobe and direction.
// - Phase A leading counts up; phase B leading counts down.
// - Illegal transitions are not flagged; no error indication exists.
// - States: A1B0 is 1, A1B1 is 2, A0B1 is 3, A0B0 is 4.
// - Binary up/down counter of 12 or 16 bits, updates on rising edges.
// - Latch copies counter every rising edge unless read-inhibit freezes it.
// - OE low/SEL low inhibits; SEL high starts release; OE high completes it.
module qdc_quadrature_decoder #(
    parameter CNT_W = 16
) (
    // Clock and bus reset
    input wire aclk,
    input wire aresetn,
    // Asynchronous position clear
    input wire clear_n,
    // Encoder phases
    input wire phase_a_in,
    input wire phase_b_in,
    // Byte read port
    input wire read_oe_n,
    input wire byte_sel,
    output wire [7:0] byte_bus,
    output wire byte_bus_oe,
    // Decoder and cascade outputs
    output wire decode_step_pulse,
    output wire wrap_pulse,
    output wire count_up,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

    localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

    ////////////////////////////////////////////////////////////////////////////
    // Noise filter, one history per phase

    wire [1:0] phase_raw;
    wire [1:0] filt;
    assign phase_raw = {phase_b_in, phase_a_in};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_filt
            reg [`QDC_HIST_W-1:0] hist_q;
            reg filt_q;
            wire [`QDC_HIST_RUN-1:0] run_w;
            // Oldest samples, past the catcher stage
            assign run_w = hist_q[`QDC_HIST_W-1:`QDC_HIST_W-`QDC_HIST_RUN];
            // Stage 0 is the metastability catcher; only stage 1 reads it
            always @(posedge aclk) begin
                if (!aresetn) begin
                    hist_q <= {`QDC_HIST_W{1'b0}};
                    filt_q <= 1'b0;
                end else begin
                    hist_q <= {hist_q[`QDC_HIST_W-2:0], phase_raw[ch]};
                    // Needs three equal stable samples to move
                    if (&run_w || ~|run_w) begin
                        filt_q <= run_w[`QDC_HIST_RUN-1];
                    end
                end
            end
            assign filt[ch] = filt_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Quadrature decoder

    reg [1:0] prev_q;
    reg strobe_q;
    reg up_q;
    wire [1:0] cur_ab;
    wire step_up;
    wire step_dn;
    // {a,b}: 10 state 1, 11 state 2, 01 state 3, 00 state 4
    assign cur_ab = {filt[0], filt[1]};
    // Up walks 1-2-3-4, i.e. A leads B
    assign step_up = (cur_ab[0] == prev_q[1]) && (cur_ab[1] == ~prev_q[0]);
    assign step_dn = (cur_ab[1] == prev_q[0]) && (cur_ab[0] == ~prev_q[1]);

    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 2'h0;
            strobe_q <= 1'b0;
            up_q <= 1'b1;
        end else begin
            prev_q <= cur_ab;
            // Every single-phase edge counts
            strobe_q <= step_up | step_dn;
            // Illegal double changes silently dropped
            if (step_up | step_dn) begin
                up_q <= step_up;
            end
        end
    end

    // Direction leads the pulse by one cycle
    assign count_up = up_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read-inhibit logic on the falling edge

    reg oe_n_s1;
    reg oe_n_s2;
    reg sel_s1;
    reg sel_s2;
    reg inhibit_q;
    reg release_q;

    always @(negedge aclk or negedge clear_n) begin
        if (!clear_n) begin
            oe_n_s1 <= 1'b1;
            oe_n_s2 <= 1'b1;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            inhibit_q <= 1'b0;
            release_q <= 1'b0;
        end else if (!aresetn) begin
            oe_n_s1 <= 1'b1;
            oe_n_s2 <= 1'b1;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            inhibit_q <= 1'b0;
            release_q <= 1'b0;
        end else begin
            oe_n_s1 <= read_oe_n;
            oe_n_s2 <= oe_n_s1;
            sel_s1 <= byte_sel;
            sel_s2 <= sel_s1;
            if (!oe_n_s2 && !sel_s2) begin
                inhibit_q <= 1'b1;
                release_q <= 1'b0;
            end else if (!oe_n_s2 && sel_s2 && inhibit_q) begin
                release_q <= 1'b1;
            end else if (oe_n_s2 && release_q) begin
                inhibit_q <= 1'b0;
                release_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Position counter and latch

    reg [CNT_W-1:0] count_q;
    reg [CNT_W-1:0] latch_q;
    reg step_tog_q;
    reg wrap_tog_q;
    reg [1:0] ctl_q;
    wire wrap_now;
    wire count_go;

    // Clear release passes two flops so no count lands on a metastable edge
    reg clr_s1_q;
    reg clr_s2_q;
    always @(posedge aclk or negedge clear_n) begin
        if (!clear_n) begin
            clr_s1_q <= 1'b0;
            clr_s2_q <= 1'b0;
        end else if (!aresetn) begin
            clr_s1_q <= 1'b1;
            clr_s2_q <= 1'b1;
        end else begin
            clr_s1_q <= 1'b1;
            clr_s2_q <= clr_s1_q;
        end
    end

    assign count_go = strobe_q & ctl_q[`QDC_CTL_COUNT_EN] & clr_s2_q;
    assign wrap_now = count_go & (up_q ? (count_q == CNT_MAX) : (count_q == CNT_ZERO));

    always @(posedge aclk or negedge clear_n) begin
        if (!clear_n) begin
            count_q <= CNT_ZERO;
            latch_q <= CNT_ZERO;
        end else if (!aresetn) begin
            count_q <= CNT_ZERO;
            latch_q <= CNT_ZERO;
        end else begin
            if (ctl_q[`QDC_CTL_SOFT_CLEAR]) begin
                count_q <= CNT_ZERO;
            end else if (count_go) begin
                // Plain binary wrap modulo width
                count_q <= up_q ? count_q + 1'b1 : count_q - 1'b1;
            end
            if (!inhibit_q) begin
                latch_q <= count_q;
            end
        end
    end

    // Toggles stay out of the clear: a cleared toggle would fake a pulse
    // against its falling-edge copy, which only the bus reset clears
    always @(posedge aclk) begin
        if (!aresetn) begin
            step_tog_q <= 1'b0;
            wrap_tog_q <= 1'b0;
        end else begin
            step_tog_q <= step_tog_q ^ count_go;
            wrap_tog_q <= wrap_tog_q ^ wrap_now;
        end
    end

    // Falling-edge copies end each pulse half a cycle after it rises
    reg step_fall_q;
    reg wrap_fall_q;
    always @(negedge aclk) begin
        if (!aresetn) begin
            step_fall_q <= 1'b0;
            wrap_fall_q <= 1'b0;
        end else begin
            step_fall_q <= step_tog_q;
            wrap_fall_q <= wrap_tog_q;
        end
    end

    // Rising edge of the wrap pulse is the cascade count trigger
    assign decode_step_pulse = step_tog_q ^ step_fall_q;
    assign wrap_pulse = wrap_tog_q ^ wrap_fall_q;

    ////////////////////////////////////////////////////////////////////////////
    // Byte bus, a straight pin-level mux

    wire [15:0] latch_wide;
    // Narrow counters read zero in the unused top bits
    assign latch_wide = {{(16-CNT_W){1'b0}}, latch_q};
    // High byte when select low, read first
    assign byte_bus = byte_sel ? latch_wide[7:0] : latch_wide[15:8];
    assign byte_bus_oe = ~read_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave, one write and one read in flight

    reg aw_full_q;
    reg [3:0] aw_addr_q;
    reg w_full_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [1:0] rresp_q;
    reg [31:0] rdata_q;
    wire wr_go;
    wire wr_hit;

    assign s_axi_awready = ~aw_full_q & ~bvalid_q;
    assign s_axi_wready = ~w_full_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    assign wr_go = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_hit = (aw_addr_q == `QDC_OFS_CONTROL);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_full_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `QDC_RESP_OKAY;
            ctl_q <= `QDC_CTL_RESET;
        end else begin
            // Soft clear lasts one cycle only
            ctl_q[`QDC_CTL_SOFT_CLEAR] <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `QDC_RESP_OKAY : `QDC_RESP_SLVERR;
                if (wr_hit && w_strb_q[0]) begin
                    ctl_q <= w_data_q[1:0];
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    reg [31:0] rd_mux;
    reg rd_err;
    always @* begin
        rd_mux = 32'h0;
        rd_err = 1'b0;
        case ({s_axi_araddr[3:2], 2'h0})
            `QDC_OFS_POSITION: rd_mux = {{(32-CNT_W){1'b0}}, count_q};
            `QDC_OFS_LATCH: rd_mux = {16'h0, latch_wide};
            `QDC_OFS_STATUS: begin
                rd_mux[`QDC_STS_FILT_A] = filt[0];
                rd_mux[`QDC_STS_FILT_B] = filt[1];
                rd_mux[`QDC_STS_INHIBIT] = inhibit_q;
                rd_mux[`QDC_STS_RELEASE] = release_q;
                rd_mux[`QDC_STS_UP] = up_q;
            end
            `QDC_OFS_CONTROL: rd_mux = {30'h0, ctl_q};
            default: rd_err = 1'b1;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= `QDC_RESP_OKAY;
            rdata_q <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_err ? `QDC_RESP_SLVERR : `QDC_RESP_OKAY;
            rdata_q <= rd_mux;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule // qdc_quadrature_decoder

//--- verilog/qdc_regs.vh
// Constants for the quadrature decoder and position counter.
// Included by the design file and the bench; holds definitions only.
`ifndef QDC_REGS_VH
`define QDC_REGS_VH

// Register byte offsets on the AXI4-Lite slave
`define QDC_OFS_POSITION 4'h0
`define QDC_OFS_LATCH 4'h4
`define QDC_OFS_STATUS 4'h8
`define QDC_OFS_CONTROL 4'hc

// Control register fields and reset value
`define QDC_CTL_COUNT_EN 0
`define QDC_CTL_SOFT_CLEAR 1
`define QDC_CTL_RESET 2'h1

// Status register fields
`define QDC_STS_FILT_A 0
`define QDC_STS_FILT_B 1
`define QDC_STS_INHIBIT 2
`define QDC_STS_RELEASE 3
`define QDC_STS_UP 4

// Noise filter history depth and the run of equal samples it needs
`define QDC_HIST_W 4
`define QDC_HIST_RUN 3

// AXI response codes
`define QDC_RESP_OKAY 2'h0
`define QDC_RESP_SLVERR 2'h2

`endif

//--- test/qdc_properties.sv
// Concurrent checks on the decoder pins and register bus.
// Assumes one clock and a synchronous active-low bus reset.
`timescale 1ns/1ps
module qdc_properties (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Pins
    input wire clear_n,
    input wire phase_a_in,
    input wire phase_b_in,
    input wire read_oe_n,
    input wire [7:0] byte_bus,
    input wire byte_bus_oe,
    input wire decode_step_pulse,
    input wire wrap_pulse,
    input wire count_up,
    // Register bus
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////
// Clocks since a phase input moved; 15 is past the worst propagation
reg [3:0] quiet_q;
reg [1:0] ph_q;
always @(posedge aclk) begin
    ph_q <= {phase_a_in, phase_b_in};
    if (!aresetn || ph_q != {phase_a_in, phase_b_in}) begin
        quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
        quiet_q <= quiet_q + 4'h1;
    end
end
bus_enable_a: assert property (byte_bus_oe == !read_oe_n)
    else $error("byte bus enable wrong");
clear_latch_a: assert property (!clear_n |-> byte_bus == 8'h00)
    else $error("latch not cleared");
step_shape_a: assert property (!decode_step_pulse)
    else $error("step pulse high at rising edge");
wrap_shape_a: assert property (!wrap_pulse)
    else $error("wrap pulse high at rising edge");
wrap_count_a: assert property (@(negedge aclk) wrap_pulse |-> decode_step_pulse)
    else $error("wrap pulse without a count");
dir_setup_a: assert property (@(negedge aclk) decode_step_pulse |-> $stable(count_up))
    else $error("direction moved with pulse");
quiet_input_a: assert property (@(negedge aclk) quiet_q == 4'hf |-> !decode_step_pulse)
    else $error("count without input change");
write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // qdc_properties
bind qdc_quadrature_decoder qdc_properties qdc_properties_i (.aclk, .aresetn, .clear_n,
    .phase_a_in, .phase_b_in, .read_oe_n, .byte_bus, .byte_bus_oe, .decode_step_pulse,
    .wrap_pulse, .count_up, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid);

//--- test/qdc_enc_model.sv
// Behavioural incremental encoder on the two phase inputs.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps
module qdc_enc_model (
    // Clock
    input wire aclk,
    // Encoder phases
    output reg phase_a_in,
    output reg phase_b_in
);
////////////////////////////////////////
reg [1:0] idx_q = 2'h0;
// Order 00,10,11,01: stepping up, A leads B by a quarter cycle
function automatic [1:0] gray(input [1:0] i);
    gray = {i[0] ^ i[1], i[1]};
endfunction
initial begin
    phase_a_in = 1'b0;
    phase_b_in = 1'b0;
end
// States held 9 clocks, well past the filter run and propagation
task step(input up, input integer n);
    repeat (n) begin
        idx_q = up ? idx_q + 2'h1 : idx_q - 2'h1;
        {phase_a_in, phase_b_in} <= gray(idx_q);
        repeat (9) @(posedge aclk);
    end
endtask
// One-clock spike on phase A, too short to qualify
task glitch;
    phase_a_in <= ~phase_a_in;
    @(posedge aclk);
    phase_a_in <= ~phase_a_in;
    repeat (12) @(posedge aclk);
endtask
endmodule // qdc_enc_model

//--- test/tb_top.sv
// Self-checking bench: encoder model, AXI4-Lite master, byte port reads.
// Assumes the header directory is on the include path.
`timescale 1ns/1ps
`include "qdc_regs.vh"
module tb_top;
////////////////////////////////////////
reg aclk = 1'b0;
reg aresetn = 1'b0;
reg clear_n = 1'b1;
reg read_oe_n = 1'b1;
reg byte_sel = 1'b0;
reg [3:0] s_axi_awaddr = 4'h0;
reg [3:0] s_axi_araddr = 4'h0;
reg [31:0] s_axi_wdata = 32'h0;
reg s_axi_awvalid = 1'b0;
reg s_axi_wvalid = 1'b0;
reg s_axi_bready = 1'b0;
reg s_axi_arvalid = 1'b0;
reg s_axi_rready = 1'b0;
wire phase_a_in, phase_b_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
wire s_axi_rvalid, decode_step_pulse, wrap_pulse, count_up, byte_bus_oe;
wire [7:0] byte_bus;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
integer mismatches = 0;
integer tests_run = 0;
integer steps = 0;
integer wraps = 0;
reg [1:0] resp;
reg [31:0] rd;
reg [15:0] v;
always #5 aclk = ~aclk;
always @(posedge decode_step_pulse) steps = steps + 1;
always @(posedge wrap_pulse) wraps = wraps + 1; // cascade counts on the rising edge
qdc_enc_model qdc_enc_model_i (.aclk, .phase_a_in, .phase_b_in);
qdc_quadrature_decoder qdc_quadrature_decoder_i (.aclk, .aresetn, .clear_n, .phase_a_in,
    .phase_b_in, .read_oe_n, .byte_sel, .byte_bus, .byte_bus_oe, .decode_step_pulse,
    .wrap_pulse, .count_up, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
task chk(input string name, input [15:0] exp, input [15:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %s expected %h seen %h", name, exp, got);
    end
endtask
// Ready sampled at the falling edge; registers only move on rising edges
task axi_wr(input [3:0] a, input [31:0] d);
    reg ta, tw, tk;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tk = 1'b0;
    while (!tk) begin
        @(negedge aclk);
        ta = s_axi_awready;
        tw = s_axi_wready;
        tk = s_axi_bvalid;
        resp = s_axi_bresp;
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
endtask
task axi_rd(input [3:0] a);
    reg ta, tk;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tk = 1'b0;
    while (!tk) begin
        @(negedge aclk);
        ta = s_axi_arready;
        tk = s_axi_rvalid;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge aclk);
        if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
endtask
// Two-byte read, n encoder steps while the latch is held
task rd_bytes(input integer n);
    read_oe_n <= 1'b0;
    byte_sel <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    v[15:8] = byte_bus;
    @(posedge aclk);
    qdc_enc_model_i.step(1'b1, n);
    byte_sel <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    v[7:0] = byte_bus;
    @(posedge aclk);
    read_oe_n <= 1'b1;
    repeat (4) @(posedge aclk);
endtask
task t_count;
    rd_bytes(0);
    chk("reset bytes", 16'h0, v);
    qdc_enc_model_i.step(1'b1, 5);
    axi_rd(`QDC_OFS_POSITION);
    chk("up pos", 16'h5, rd[15:0]);
    chk("up dir", 16'h1, {15'h0, count_up});
    chk("steps", 16'd5, steps);
    qdc_enc_model_i.step(1'b0, 7);
    axi_rd(`QDC_OFS_POSITION);
    chk("down pos", 16'hfffe, rd[15:0]);
    chk("down dir", 16'h0, {15'h0, count_up});
    chk("wraps", 16'd1, wraps);
    $display("count test done");
endtask
task t_inhibit;
    rd_bytes(3);
    chk("held", 16'hfffe, v);
    rd_bytes(0);
    chk("reloaded", 16'h1, v);
    chk("wraps", 16'd2, wraps);
    qdc_enc_model_i.glitch;
    axi_rd(`QDC_OFS_POSITION);
    chk("spike", 16'h1, rd[15:0]);
    $display("latch test done");
endtask
task t_regs;
    axi_wr(`QDC_OFS_POSITION, 32'h0);
    chk("ro write", `QDC_RESP_SLVERR, resp);
    // Byte lanes inside a word are ignored: offset 2 reads the position
    axi_rd(4'h2);
    chk("low bits resp", `QDC_RESP_OKAY, resp);
    chk("low bits pos", 16'h1, rd[15:0]);
    axi_wr(`QDC_OFS_CONTROL, 32'h0);
    qdc_enc_model_i.step(1'b1, 2);
    axi_rd(`QDC_OFS_POSITION);
    chk("disabled", 16'h1, rd[15:0]);
    axi_wr(`QDC_OFS_CONTROL, 32'h1);
    chk("ctl write", `QDC_RESP_OKAY, resp);
    axi_wr(`QDC_OFS_CONTROL, 32'h3);
    axi_rd(`QDC_OFS_POSITION);
    chk("soft clear", 16'h0, rd[15:0]);
    qdc_enc_model_i.step(1'b1, 1);
    $display("register test done");
endtask
// Clear lands mid-cycle with the latch held; the bus must drop before any edge
task t_clear;
    read_oe_n <= 1'b0;
    byte_sel <= 1'b0;
    repeat (4) @(posedge aclk);
    axi_rd(`QDC_OFS_STATUS);
    chk("inhibit set", 16'h1, {15'h0, rd[`QDC_STS_INHIBIT]});
    byte_sel <= 1'b1;
    @(posedge aclk);
    #3 chk("held low byte", 16'h1, {8'h0, byte_bus});
    clear_n = 1'b0;
    #1 chk("async clear", 16'h0, {8'h0, byte_bus});
    @(posedge aclk);
    #3 clear_n = 1'b1;
    repeat (3) @(posedge aclk);
    axi_rd(`QDC_OFS_STATUS);
    chk("clear inhibit", 16'h0, {15'h0, rd[`QDC_STS_INHIBIT]});
    axi_rd(`QDC_OFS_POSITION);
    chk("cleared pos", 16'h0, rd[15:0]);
    read_oe_n <= 1'b1;
    $display("clear test done");
endtask
task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask
initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_count;
    t_inhibit;
    t_regs;
    t_clear;
    print_verdict;
end
initial begin
    #50000;
    mismatches = mismatches + 1;
    print_verdict;
end
endmodule // tb_top
